// >>> src/dspw_ctrl.sv
// serial-programmed dual-slot power switch control logic
// Operation
// - shift data bit in on every rising serial clock edge
// - latch rising edge moves eleven shifted bits into active word
// - power-down bit selecting shutdown puts all outputs high impedance
// - either reset closes the four discharge switches and puts all four slot outputs in discharge
// - stay grounded after reset until a new word is latched
// - latch edges during reset are ignored
// - reset state is entered automatically at power-up
// - two reset inputs, high and low active, weakly held deasserted
// - mode low gives dependent programming supply, high independent
// - overcurrent on any output drives flag low
// - overtemperature also drives the flag low
// - overcurrent limits only the affected output
// - overheating turns all outputs off until cooled past hysteresis
// - low standby input reduces every output current limit
// - supply codes 00/11 off, 01 3.3 V, 10 5 V; legacy copy
// - independent programming codes 0 V, 3.3/5 V, 12 V, high Z
`timescale 1ns/1ps
`default_nettype none
module dspw_ctrl
    import dspw_pkg::*;
#(
    parameter int N_OUT = 4
) (
    // system clock and reset
    input wire logic REF_CLK_IN,
    input wire logic RST_IN,
    // serial link, clocked by the host serial clock
    input wire logic SER_CLK_IN,
    input wire logic SER_DATA_IN,
    input wire logic SER_LATCH_IN,
    // reset and mode pins, already resolved for internal pulls
    input wire logic CARD_RESET_IN,
    input wire logic CARD_RESET_N_IN,
    input wire logic MODE_INDEPENDENT_IN,
    input wire logic LOW_POWER_LIMIT_N_IN,
    // analog sense inputs: a, a prog, b, b prog
    input wire logic [N_OUT-1:0] OVERCURRENT_IN,
    input wire logic OVERTEMP_IN,
    input wire logic COOLED_IN,
    // output switch states, one-hot per slot output
    output logic [5:0] SLOT_A_SUPPLY_OUT,
    output logic [5:0] SLOT_A_PROG_OUT,
    output logic [5:0] SLOT_B_SUPPLY_OUT,
    output logic [5:0] SLOT_B_PROG_OUT,
    output logic [3:0] DISCHARGE_SWITCH_OUT,
    output logic [N_OUT-1:0] CURRENT_LIMIT_OUT,
    output logic LOW_LIMIT_OUT,
    output logic OVERCURRENT_FLAG_N_OUT,
    output logic [10:0] SWITCH_CONTROL_WORD_OUT
);
    // ======================================================
    // link domain: shift register and latch capture
    // ======================================================
    logic [10:0] shift_reg;
    logic [10:0] link_word;
    logic link_toggle;
    logic latch_rst;
    logic any_reset;

    assign any_reset = CARD_RESET_IN | ~CARD_RESET_N_IN;

    always_ff @(posedge SER_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            shift_reg <= WORD_RESET;
        end else begin
            // msb first: last bit shifted lands at position zero
            shift_reg <= {shift_reg[9:0], SER_DATA_IN};
        end
    end

    // latch edge is its own clock; reset pins block capture asynchronously
    assign latch_rst = RST_IN | any_reset;

    always_ff @(posedge SER_LATCH_IN or posedge latch_rst) begin
        if (latch_rst) begin
            link_word <= WORD_RESET;
        end else begin
            link_word <= shift_reg;
        end
    end

    always_ff @(posedge SER_LATCH_IN or posedge RST_IN) begin
        if (RST_IN) begin
            link_toggle <= 1'b0;
        end else if (!any_reset) begin
            link_toggle <= ~link_toggle;
        end
    end

    // ======================================================
    // crossing into the system clock domain
    // ======================================================
    logic toggle_s;
    logic toggle_d;
    logic [4:0] pins_s;
    logic [N_OUT:0] sense_s;
    logic new_word;

    dspw_sync #(.W(1), .INIT(1'b0)) u_tog (
        .clk_in(REF_CLK_IN),
        .rst_in(RST_IN),
        .d_in(link_toggle),
        .q_out(toggle_s)
    );
    // reset pins start asserted so power-up begins grounded
    // standby starts idle so no false low limit follows reset
    dspw_sync #(.W(5), .INIT(PINS_INIT)) u_pins (
        .clk_in(REF_CLK_IN),
        .rst_in(RST_IN),
        .d_in({CARD_RESET_IN, ~CARD_RESET_N_IN, LOW_POWER_LIMIT_N_IN,
               MODE_INDEPENDENT_IN, COOLED_IN}),
        .q_out(pins_s)
    );
    dspw_sync #(.W(N_OUT + 1), .INIT('0)) u_sense (
        .clk_in(REF_CLK_IN),
        .rst_in(RST_IN),
        .d_in({OVERTEMP_IN, OVERCURRENT_IN}),
        .q_out(sense_s)
    );

    always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            toggle_d <= 1'b0;
        end else begin
            toggle_d <= toggle_s;
        end
    end
    assign new_word = toggle_s ^ toggle_d;

    logic rst_s;
    logic low_power_limit_n_n_s;
    logic indep_s;
    logic cooled_s;
    logic hot_s;
    logic [N_OUT-1:0] oc_s;
    assign rst_s = pins_s[4] | pins_s[3];
    assign low_power_limit_n_n_s = pins_s[2];
    assign indep_s = pins_s[1];
    assign cooled_s = pins_s[0];
    assign hot_s = sense_s[N_OUT];
    assign oc_s = sense_s[N_OUT-1:0];

    // ======================================================
    // control state and active word
    // ======================================================
    dspw_state_t state;
    logic [10:0] active_word;

    // word is stable in the link domain for many clocks after the toggle
    always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            active_word <= WORD_RESET;
        end else if (rst_s) begin
            // reset pins drop the word too, so none survives reset
            active_word <= WORD_RESET;
        end else if (new_word) begin
            active_word <= link_word;
        end
    end

    always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            state <= ST_RESET;
        end else begin
            case (state)
                ST_RESET: begin
                    if (!rst_s && new_word) begin
                        state <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (rst_s) begin
                        state <= ST_RESET;
                    end else if (hot_s) begin
                        state <= ST_HOT;
                    end
                end
                ST_HOT: begin
                    if (rst_s) begin
                        state <= ST_RESET;
                    end else if (!hot_s && cooled_s) begin
                        state <= ST_RUN;
                    end
                end
                default: begin
                    state <= ST_RESET;
                end
            endcase
        end
    end

    // ======================================================
    // voltage decode
    // ======================================================
    function automatic dspw_out_t sup_dec(input logic [1:0] code);
        case (code)
            SUP_3V3: sup_dec = OUT_3V3;
            SUP_5V: sup_dec = OUT_5V;
            default: sup_dec = OUT_GND;
        endcase
    endfunction

    function automatic dspw_out_t prog_dec(input logic [1:0] code,
                                           input logic lvl,
                                           input logic indep,
                                           input dspw_out_t sup);
        case (code)
            PROG_0V: prog_dec = OUT_GND;
            PROG_LOW: begin
                if (indep) begin
                    prog_dec = lvl ? OUT_5V : OUT_3V3;
                end else begin
                    prog_dec = sup;
                end
            end
            PROG_12V: prog_dec = OUT_12V;
            default: prog_dec = OUT_HIZ;
        endcase
    endfunction

    dspw_out_t a_sup;
    dspw_out_t b_sup;
    dspw_out_t a_prog;
    dspw_out_t b_prog;
    logic word_on;

    assign word_on = active_word[POS_ON];
    assign a_sup = sup_dec({active_word[POS_A_SUP_HI],
                            active_word[POS_A_SUP_LO]});
    assign b_sup = sup_dec({active_word[POS_B_SUP_HI],
                            active_word[POS_B_SUP_LO]});
    assign a_prog = prog_dec({active_word[POS_A_PROG0],
                              active_word[POS_A_PROG1]},
                             active_word[POS_A_LVL], indep_s, a_sup);
    assign b_prog = prog_dec({active_word[POS_B_PROG0],
                              active_word[POS_B_PROG1]},
                             active_word[POS_B_LVL], indep_s, b_sup);

    // ======================================================
    // registered outputs
    // ======================================================
    always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            SLOT_A_SUPPLY_OUT <= OUT_DIS;
            SLOT_A_PROG_OUT <= OUT_DIS;
            SLOT_B_SUPPLY_OUT <= OUT_DIS;
            SLOT_B_PROG_OUT <= OUT_DIS;
            DISCHARGE_SWITCH_OUT <= DIS_ALL;
        end else if (rst_s || state == ST_RESET) begin
            SLOT_A_SUPPLY_OUT <= OUT_DIS;
            SLOT_A_PROG_OUT <= OUT_DIS;
            SLOT_B_SUPPLY_OUT <= OUT_DIS;
            SLOT_B_PROG_OUT <= OUT_DIS;
            DISCHARGE_SWITCH_OUT <= DIS_ALL;
        end else if (!word_on || state == ST_HOT) begin
            SLOT_A_SUPPLY_OUT <= OUT_HIZ;
            SLOT_A_PROG_OUT <= OUT_HIZ;
            SLOT_B_SUPPLY_OUT <= OUT_HIZ;
            SLOT_B_PROG_OUT <= OUT_HIZ;
            DISCHARGE_SWITCH_OUT <= DIS_NONE;
        end else begin
            SLOT_A_SUPPLY_OUT <= a_sup;
            SLOT_A_PROG_OUT <= a_prog;
            SLOT_B_SUPPLY_OUT <= b_sup;
            SLOT_B_PROG_OUT <= b_prog;
            DISCHARGE_SWITCH_OUT <= DIS_NONE;
        end
    end

    always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            CURRENT_LIMIT_OUT <= '0;
            OVERCURRENT_FLAG_N_OUT <= 1'b1;
        end else begin
            CURRENT_LIMIT_OUT <= oc_s;
            OVERCURRENT_FLAG_N_OUT <= ~(|oc_s | hot_s);
        end
    end

    always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            LOW_LIMIT_OUT <= 1'b0;
        end else begin
            // limitation: host must settle switches first, see standby use
            LOW_LIMIT_OUT <= ~low_power_limit_n_n_s;
        end
    end

    always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            SWITCH_CONTROL_WORD_OUT <= WORD_RESET;
        end else begin
            SWITCH_CONTROL_WORD_OUT <= active_word;
        end
    end
endmodule
`default_nettype wire

// >>> include/dspw_pkg.sv
// constants and types shared by the dual-slot power switch control logic
`default_nettype none
package dspw_pkg;
    localparam int WORD_W = 11;
    // control word field positions
    localparam int POS_A_PROG0 = 0;
    localparam int POS_A_PROG1 = 1;
    localparam int POS_A_SUP_LO = 2;
    localparam int POS_A_SUP_HI = 3;
    localparam int POS_B_PROG0 = 4;
    localparam int POS_B_PROG1 = 5;
    localparam int POS_B_SUP_HI = 6;
    localparam int POS_B_SUP_LO = 7;
    localparam int POS_ON = 8;
    localparam int POS_A_LVL = 9;
    localparam int POS_B_LVL = 10;
    localparam logic [10:0] WORD_RESET = 11'h000;
    // discharge switch settings: all closed, all open
    localparam logic [3:0] DIS_ALL = 4'hf;
    localparam logic [3:0] DIS_NONE = 4'h0;
    // pin sync preset: reset pins asserted, standby idle, cooled
    localparam logic [4:0] PINS_INIT = 5'h1d;
    // two-bit selection codes
    localparam logic [1:0] SUP_OFF0 = 2'h0;
    localparam logic [1:0] SUP_3V3 = 2'h1;
    localparam logic [1:0] SUP_5V = 2'h2;
    localparam logic [1:0] PROG_0V = 2'h0;
    localparam logic [1:0] PROG_LOW = 2'h1;
    localparam logic [1:0] PROG_12V = 2'h2;
    localparam logic [1:0] PROG_HIZ = 2'h3;
    // output state encoding, one-hot
    typedef enum logic [5:0] {
        OUT_GND = 6'h01,
        OUT_3V3 = 6'h02,
        OUT_5V = 6'h04,
        OUT_12V = 6'h08,
        OUT_HIZ = 6'h10,
        OUT_DIS = 6'h20
    } dspw_out_t;
    // control states, one-hot
    typedef enum logic [2:0] {
        ST_RESET = 3'h1,
        ST_RUN = 3'h2,
        ST_HOT = 3'h4
    } dspw_state_t;
endpackage
`default_nettype wire

// >>> src/dspw_sync.sv
// two-flop synchroniser for a bus of levels
`timescale 1ns/1ps
`default_nettype none
module dspw_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [W-1:0] d_in,
    output logic [W-1:0] q_out
);
    logic [W-1:0] meta;
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            meta <= INIT;
            q_out <= INIT;
        end else begin
            meta <= d_in;
            q_out <= meta;
        end
    end
endmodule
`default_nettype wire

// >>> dv/dspw_ctrl_sva.sv
// assertion checker for the dual-slot power switch control
`timescale 1ns/1ps
`default_nettype none
module dspw_ctrl_chk
    import dspw_pkg::*;
#(
    parameter int N_OUT = 4
) (
    input wire logic REF_CLK_IN,
    input wire logic RST_IN,
    input wire logic SER_CLK_IN,
    input wire logic SER_DATA_IN,
    input wire logic SER_LATCH_IN,
    input wire logic CARD_RESET_IN,
    input wire logic CARD_RESET_N_IN,
    input wire logic LOW_POWER_LIMIT_N_IN,
    input wire logic [N_OUT-1:0] OVERCURRENT_IN,
    input wire logic OVERTEMP_IN,
    input wire logic [5:0] SLOT_A_SUPPLY_OUT,
    input wire logic [5:0] SLOT_B_PROG_OUT,
    input wire logic [3:0] DISCHARGE_SWITCH_OUT,
    input wire logic [N_OUT-1:0] CURRENT_LIMIT_OUT,
    input wire logic LOW_LIMIT_OUT,
    input wire logic OVERCURRENT_FLAG_N_OUT,
    input wire logic [10:0] SWITCH_CONTROL_WORD_OUT
);
    // ==========================================
    // link shadow; the host parks its clock, so it holds
    logic [10:0] shadow;
    wire logic pins_idle = !CARD_RESET_IN && CARD_RESET_N_IN;
    always_ff @(posedge SER_CLK_IN) begin
        shadow <= {shadow[9:0], SER_DATA_IN};
    end
    default clocking dcb @(posedge REF_CLK_IN); endclocking
    default disable iff (RST_IN);
    sequence s_take;
        $rose(SER_LATCH_IN) && pins_idle;
    endsequence
    sequence s_quiet;
        pins_idle [*8];
    endsequence
    property p_load;
        s_take ##0 s_quiet |-> SWITCH_CONTROL_WORD_OUT == shadow;
    endproperty
    a_load: assert property (p_load) else $error("word not loaded");
    property p_hold;
        $changed(SWITCH_CONTROL_WORD_OUT) && pins_idle |-> SER_LATCH_IN;
    endproperty
    a_hold: assert property (p_hold) else $error("word moved");
    property p_clear;
        (CARD_RESET_IN || !CARD_RESET_N_IN) [*6] |->
            DISCHARGE_SWITCH_OUT == 4'hf && SLOT_A_SUPPLY_OUT == OUT_DIS;
    endproperty
    a_clear: assert property (p_clear)
        else $error("no discharge");
    property p_ignore;
        CARD_RESET_IN [*6] |-> SWITCH_CONTROL_WORD_OUT == 11'h000;
    endproperty
    a_ignore: assert property (p_ignore)
        else $error("word in reset");
    property p_shut;
        !SWITCH_CONTROL_WORD_OUT[POS_ON] && DISCHARGE_SWITCH_OUT == 4'h0
            && $stable(SWITCH_CONTROL_WORD_OUT) |->
            SLOT_A_SUPPLY_OUT == OUT_HIZ && SLOT_B_PROG_OUT == OUT_HIZ;
    endproperty
    a_shut: assert property (p_shut)
        else $error("shutdown not hiz");
    property p_oc;
        (|OVERCURRENT_IN) [*5] |-> !OVERCURRENT_FLAG_N_OUT;
    endproperty
    a_oc: assert property (p_oc) else $error("flag missing");
    property p_lim;
        $stable(OVERCURRENT_IN) [*5] |-> CURRENT_LIMIT_OUT == OVERCURRENT_IN;
    endproperty
    a_lim: assert property (p_lim) else $error("wrong limit");
    // a held reset grounds the outputs instead, which is also off
    property p_hot;
        OVERTEMP_IN [*6] |-> !OVERCURRENT_FLAG_N_OUT &&
            (SLOT_A_SUPPLY_OUT == OUT_HIZ || DISCHARGE_SWITCH_OUT == 4'hf);
    endproperty
    a_hot: assert property (p_hot)
        else $error("hot not off");
    property p_low_power_limit_n;
        $stable(LOW_POWER_LIMIT_N_IN) [*5] |->
            LOW_LIMIT_OUT == !LOW_POWER_LIMIT_N_IN;
    endproperty
    a_low_power_limit_n: assert property (p_low_power_limit_n) else $error("low limit");
endmodule
bind dspw_ctrl dspw_ctrl_chk #(.N_OUT(N_OUT)) u_chk (.*);
`default_nettype wire

// >>> dv/dspw_host.sv
// behavioural host serial controller for the latch-loaded link
`timescale 1ns/1ps
`default_nettype none
module dspw_host (
    // serial link toward the switch
    output logic ser_clk_out,
    output logic ser_data_out,
    output logic ser_latch_out
);
    initial begin
        ser_clk_out = 1'b0;
        ser_data_out = 1'b1;
        ser_latch_out = 1'b0;
    end
    // ==========================================
    // frame: msb first, 80 ns clock, parked low between frames
    task automatic send(input logic [10:0] w);
        // start mid-cycle so no link edge meets a rising system clock edge
        #5;
        for (int i = 10; i >= 0; i--) begin
            ser_data_out = w[i];
            #20 ser_clk_out = 1'b1;
            #40 ser_clk_out = 1'b0;
            #20;
        end
        ser_latch_out = 1'b1;
        #40 ser_latch_out = 1'b0;
        // released line must not look like held data
        ser_data_out = ~w[0];
    endtask
endmodule
`default_nettype wire

// >>> dv/dspw_ctrl_tb.sv
// self-checking bench for the dual-slot power switch control
`timescale 1ns/1ps
`default_nettype none
module dspw_ctrl_tb;
    import dspw_pkg::*;
    logic clk, rst, crst, crst_n, mode, low_power_limit_n_n, hot, cool;
    logic [3:0] oc, dis, lim;
    wire logic sck, sda, slt;
    logic [5:0] a_sup, a_pg, b_sup, b_pg;
    logic low_lim, flag_n;
    logic [10:0] word;
    int miscompares = 0;
    int n_tests = 0;
    int cycles = 0;
    dspw_host u_host (.ser_clk_out(sck), .ser_data_out(sda),
        .ser_latch_out(slt));
    dspw_ctrl u_dut (.REF_CLK_IN(clk), .RST_IN(rst), .SER_CLK_IN(sck),
        .SER_DATA_IN(sda), .SER_LATCH_IN(slt), .CARD_RESET_IN(crst),
        .CARD_RESET_N_IN(crst_n), .MODE_INDEPENDENT_IN(mode),
        .LOW_POWER_LIMIT_N_IN(low_power_limit_n_n), .OVERCURRENT_IN(oc),
        .OVERTEMP_IN(hot), .COOLED_IN(cool), .SLOT_A_SUPPLY_OUT(a_sup),
        .SLOT_A_PROG_OUT(a_pg), .SLOT_B_SUPPLY_OUT(b_sup),
        .SLOT_B_PROG_OUT(b_pg), .DISCHARGE_SWITCH_OUT(dis),
        .CURRENT_LIMIT_OUT(lim), .LOW_LIMIT_OUT(low_lim),
        .OVERCURRENT_FLAG_N_OUT(flag_n), .SWITCH_CONTROL_WORD_OUT(word));
    // ==========================================
    // helpers
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    function automatic logic [5:0] es(input logic [1:0] c);
        return (c == 2'h1) ? OUT_3V3 : (c == 2'h2) ? OUT_5V : OUT_GND;
    endfunction
    function automatic logic [5:0] ep(input logic [1:0] c, input logic lv,
            input logic ind, input logic [5:0] s);
        if (c == 2'h1) begin
            return ind ? (lv ? OUT_5V : OUT_3V3) : s;
        end
        return (c == 2'h0) ? OUT_GND : (c == 2'h2) ? OUT_12V : OUT_HIZ;
    endfunction
    function automatic logic [10:0] mk(input logic [1:0] c);
        return {~c[0], c[0], 1'b1, ~c[0], ~c[1], c[0], c[1], c[1], c[0],
            c[0], c[1]};
    endfunction
    task automatic load(input logic [10:0] w);
        u_host.send(w);
        wt(12);
    endtask
    task automatic chk_all(input logic [1:0] c);
        chk(a_sup, es(c));
        chk(a_pg, ep(c, c[0], mode, es(c)));
        chk(b_sup, es(~c));
        chk(b_pg, ep(c, ~c[0], mode, es(~c)));
        chk(word, mk(c));
    endtask
    // ==========================================
    // scenarios
    task automatic t_power_up();
        wt(2);
        chk(dis, 4'hf);
        chk(word, 11'h000);
        wt(30);
        chk(a_sup, OUT_DIS);
    endtask
    task automatic t_codes();
        for (int m = 0; m < 2; m++) begin
            mode = m[0];
            for (int c = 0; c < 4; c++) begin
                load(mk(c[1:0]));
                chk_all(c[1:0]);
            end
        end
        load(mk(2'h1) & 11'h6ff);
        chk(a_sup, OUT_HIZ);
        chk(b_pg, OUT_HIZ);
    endtask
    task automatic t_pins();
        for (int p = 0; p < 2; p++) begin
            crst = p[0];
            crst_n = p[0];
            wt(6);
            chk(dis, 4'hf);
            chk(a_pg, OUT_DIS);
            load(mk(2'h1));
            chk(word, 11'h000);
            crst = 1'b0;
            crst_n = 1'b1;
            wt(8);
            chk(b_sup, OUT_DIS);
            load(mk(2'h2));
            chk_all(2'h2);
        end
    endtask
    task automatic t_faults();
        for (int i = 0; i < 4; i++) begin
            oc = 4'h1 << i;
            wt(6);
            chk(lim, oc);
            chk(flag_n, 1'b0);
            oc = 4'h0;
            wt(6);
            chk(flag_n, 1'b1);
        end
        hot = 1'b1;
        wt(6);
        chk(flag_n, 1'b0);
        chk(b_pg, OUT_HIZ);
        hot = 1'b0;
        wt(6);
        chk(a_sup, OUT_HIZ);
        cool = 1'b1;
        wt(6);
        chk_all(2'h2);
        cool = 1'b0;
        low_power_limit_n_n = 1'b0;
        wt(6);
        chk(low_lim, 1'b1);
        low_power_limit_n_n = 1'b1;
        wt(6);
        chk(low_lim, 1'b0);
    endtask
    // ==========================================
    // clock, watchdog and main sequence
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 30000) begin
            miscompares++;
            report_and_stop();
        end
    end
    initial begin
        rst = 1'b1;
        crst = 1'b0;
        crst_n = 1'b1;
        mode = 1'b0;
        low_power_limit_n_n = 1'b1;
        hot = 1'b0;
        cool = 1'b0;
        oc = 4'h0;
        wt(8);
        rst = 1'b0;
        t_power_up();
        t_codes();
        t_pins();
        t_faults();
        report_and_stop();
    end
endmodule
`default_nettype wire
